// >>> rtl/bcs_regs.sv
// Control and status register bank of the step-down converter
//
// Function
// R1: On turn-off, connect switch-node discharge only if discharge bit 4 set; resets 1.
// R2: Host should clear discharge bit when a standby supply sits on the output.
// R3: Select pin low: low-set mode bit 7 picks auto (0) or forced PWM (1).
// R4: Select pin high: high-set mode bit 6 picks auto (0) or forced PWM (1).
// R5: Two-bit code bits 7:6 selects peak limit 4.7/5.2/5.7/6.2 A; resets 11.
// R6: Overcurrent event sets flag bit 7; reads 0 while nothing recorded.
// R7: Output short-circuit event sets flag bit 4; otherwise reads 0.
// R8: Input undervoltage after enable sets flag bit 1.
// R9: Select pin chooses low voltage set when low, high set when high.
// R10: Event flags stay set until host writes 0; writing 1 creates nothing.
// R11: Reserved bits ignore writes and read as zero.
`timescale 1ns/10ps
`include "bcs_params.svh"


module bcs_regs
(
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire bcs_pkg::bcs_reg_req_s reg_req,
    output logic [7:0]                reg_rdata,
    input  wire logic                 voltage_set_select_pin,
    input  wire logic                 converter_enabled,
    input  wire bcs_pkg::bcs_fault_s  fault_event,
    output logic                      discharge_path_en,
    output logic                      high_set_active,
    output bcs_pkg::bcs_sw_mode_e     switch_mode,
    output bcs_pkg::bcs_ilim_t        inductor_current_limit_code,
    output bcs_pkg::bcs_fault_s       fault_flags
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Offset match, shared by the write and read decoders
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic bcs_pkg::bcs_sw_mode_e mode_of(input logic forced);
        mode_of = forced ? bcs_pkg::BCS_MODE_FORCED_PWM : bcs_pkg::BCS_MODE_AUTO;
    endfunction : mode_of

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic               discharge_q;
    logic               low_set_mode_bit_q;
    logic               high_set_mode_bit_q;
    bcs_pkg::bcs_ilim_t ilim_code_q;
    logic [2:0]         flag_q;
    logic [2:0]         event_vec;
    logic [2:0]         flag_wbit;
    logic [7:0]         rdata_d;
    logic               flags_wr;
    logic               sel_forced;

    // ----------------------------------------------------------------
    // Discharge control
    // ----------------------------------------------------------------
    // R1 discharge bit store
    // R11 only bit 4 is stored, other bits of the word are dropped
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            discharge_q <= `BCS_RST_DISCHARGE;
        end
        else if (reg_req.wr && hit(reg_req.addr, `BCS_OFS_DISCHARGE))
        begin
            discharge_q <= reg_req.wdata[`BCS_POS_DISCHARGE];
        end
    end

    // ----------------------------------------------------------------
    // Switching mode bits
    // ----------------------------------------------------------------
    // R3 R4 mode bit store
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_set_mode_bit_q  <= `BCS_RST_LOW_SET_MODE;
            high_set_mode_bit_q <= `BCS_RST_HIGH_SET_MODE;
        end
        else if (reg_req.wr && hit(reg_req.addr, `BCS_OFS_SWITCH_MODE))
        begin
            low_set_mode_bit_q  <= reg_req.wdata[`BCS_POS_LOW_SET_MODE];
            high_set_mode_bit_q <= reg_req.wdata[`BCS_POS_HIGH_SET_MODE];
        end
    end

    // ----------------------------------------------------------------
    // Peak current limit code
    // ----------------------------------------------------------------
    // R5 limit code store
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ilim_code_q <= `BCS_RST_ILIM_CODE;
        end
        else if (reg_req.wr && hit(reg_req.addr, `BCS_OFS_CURRENT_LIMIT))
        begin
            ilim_code_q <= reg_req.wdata[`BCS_POS_ILIM_MSB:`BCS_POS_ILIM_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    assign flags_wr = reg_req.wr && hit(reg_req.addr, `BCS_OFS_FAULT_FLAGS);

    // R6 overcurrent
    assign event_vec[2] = fault_event.overcurrent;
    // R7 short circuit
    assign event_vec[1] = fault_event.short_circuit;
    // R8 undervoltage counts only once enabled
    assign event_vec[0] = fault_event.input_undervoltage && converter_enabled;

    // R10 a zero in the flag position clears it
    assign flag_wbit[2] = reg_req.wdata[`BCS_POS_OVERCURRENT];
    assign flag_wbit[1] = reg_req.wdata[`BCS_POS_SHORT_CIRCUIT];
    assign flag_wbit[0] = reg_req.wdata[`BCS_POS_INPUT_UV];

    // R10 sticky, cleared by a zero write
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_flag
            bcs_event_flag u_flag
            (
                .sys_clk   (sys_clk),
                .arst_n    (arst_n),
                .event_in  (event_vec[i]),
                .clear_wr  (flags_wr),
                .clear_bit (flag_wbit[i]),
                .flag_q    (flag_q[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // R11 reserved and unmapped bits read zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (hit(reg_req.addr, `BCS_OFS_DISCHARGE))
        begin
            rdata_d[`BCS_POS_DISCHARGE] = discharge_q;
        end
        else if (hit(reg_req.addr, `BCS_OFS_SWITCH_MODE))
        begin
            rdata_d[`BCS_POS_LOW_SET_MODE]  = low_set_mode_bit_q;
            rdata_d[`BCS_POS_HIGH_SET_MODE] = high_set_mode_bit_q;
        end
        else if (hit(reg_req.addr, `BCS_OFS_CURRENT_LIMIT))
        begin
            rdata_d[`BCS_POS_ILIM_MSB:`BCS_POS_ILIM_LSB] = ilim_code_q;
        end
        else if (hit(reg_req.addr, `BCS_OFS_FAULT_FLAGS))
        begin
            rdata_d[`BCS_POS_OVERCURRENT]   = flag_q[2];
            rdata_d[`BCS_POS_SHORT_CIRCUIT] = flag_q[1];
            rdata_d[`BCS_POS_INPUT_UV]      = flag_q[0];
        end
    end

    // Holds the last read until the next read request
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= `BCS_RST_RDATA;
        end
        else if (reg_req.rd)
        begin
            reg_rdata <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Power stage controls
    // ----------------------------------------------------------------
    // R3 R4 mode bit of the selected set
    assign sel_forced = voltage_set_select_pin ? high_set_mode_bit_q : low_set_mode_bit_q;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            discharge_path_en           <= 1'b0;
            high_set_active             <= 1'b0;
            switch_mode                 <= bcs_pkg::BCS_MODE_AUTO;
            inductor_current_limit_code <= `BCS_RST_ILIM_CODE;
        end
        else
        begin
            // R1 discharge only while off and enabled by the bit
            discharge_path_en           <= !converter_enabled && discharge_q;
            // R9 set selection follows the pin
            high_set_active             <= voltage_set_select_pin;
            // R3 R4 selected set governs switching
            switch_mode                 <= mode_of(sel_forced);
            // R5 limit code to the current comparator
            inductor_current_limit_code <= ilim_code_q;
        end
    end

    // ----------------------------------------------------------------
    // Flag outputs
    // ----------------------------------------------------------------
    // R6 R7 R8 recorded flags to the power stage
    assign fault_flags.overcurrent        = flag_q[2];
    assign fault_flags.short_circuit      = flag_q[1];
    assign fault_flags.input_undervoltage = flag_q[0];

endmodule : bcs_regs

// >>> rtl/bcs_params.svh
// Offsets, field positions, reset values of the converter control and status registers
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BCS_OFS_DISCHARGE      8'h12
`define BCS_OFS_SWITCH_MODE    8'h14
`define BCS_OFS_CURRENT_LIMIT  8'h16
`define BCS_OFS_FAULT_FLAGS    8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BCS_POS_DISCHARGE      4
`define BCS_POS_LOW_SET_MODE   7
`define BCS_POS_HIGH_SET_MODE  6
`define BCS_POS_ILIM_MSB       7
`define BCS_POS_ILIM_LSB       6
`define BCS_POS_OVERCURRENT    7
`define BCS_POS_SHORT_CIRCUIT  4
`define BCS_POS_INPUT_UV       1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BCS_RST_DISCHARGE      1'h1
`define BCS_RST_LOW_SET_MODE   1'h0
`define BCS_RST_HIGH_SET_MODE  1'h0
`define BCS_RST_ILIM_CODE      2'h3
`define BCS_RST_FLAG           1'h0
`define BCS_RST_RDATA          8'h00

`endif

// >>> rtl/bcs_pkg.sv
// Types shared by the converter control and status register bank
package bcs_pkg;

    // Register access from the serial interface engine
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } bcs_reg_req_s;

    // Protection events and their recorded flags
    typedef struct packed {
        logic overcurrent;
        logic short_circuit;
        logic input_undervoltage;
    } bcs_fault_s;

    // Switching behaviour requested of the power stage
    typedef enum logic {
        BCS_MODE_AUTO,
        BCS_MODE_FORCED_PWM
    } bcs_sw_mode_e;

    // Inductor peak current limit code: 00 4.7A, 01 5.2A, 10 5.7A, 11 6.2A
    typedef logic [1:0] bcs_ilim_t;

endpackage : bcs_pkg

// >>> rtl/bcs_event_flag.sv
// Sticky protection event flag, cleared by writing zero
`timescale 1ns/10ps
`include "bcs_params.svh"

module bcs_event_flag
(
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic event_in,
    input  wire logic clear_wr,
    input  wire logic clear_bit,
    output logic      flag_q
);

    logic flag_d;

    // Set wins over a clear in the same cycle; writing one changes nothing
    always_comb
    begin
        flag_d = flag_q;
        if (clear_wr && !clear_bit)
        begin
            flag_d = 1'b0;
        end
        if (event_in)
        begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_q <= `BCS_RST_FLAG;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

endmodule : bcs_event_flag

// >>> verification/bcs_regs_asserts.sv
// Concurrent checks on the converter control and status register bank
`timescale 1ns/10ps

module bcs_regs_asserts
(
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    input wire bcs_pkg::bcs_reg_req_s reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  voltage_set_select_pin,
    input wire logic                  converter_enabled,
    input wire bcs_pkg::bcs_fault_s   fault_event,
    input wire logic                  discharge_path_en,
    input wire logic                  high_set_active,
    input wire bcs_pkg::bcs_sw_mode_e switch_mode,
    input wire bcs_pkg::bcs_ilim_t    inductor_current_limit_code,
    input wire bcs_pkg::bcs_fault_s   fault_flags
);
    logic       dis_q;
    logic       m0_q;
    logic       m1_q;
    logic [1:0] il_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Shadow of the stored control fields
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dis_q <= 1'b1;
            m0_q  <= 1'b0;
            m1_q  <= 1'b0;
            il_q  <= 2'h3;
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == 8'h12)
                dis_q <= reg_req.wdata[4];
            if (reg_req.addr == 8'h14)
                {m0_q, m1_q} <= reg_req.wdata[7:6];
            if (reg_req.addr == 8'h16)
                il_q <= reg_req.wdata[7:6];
        end
    end

    chk_discharge_path: assert property (
        $past(arst_n) |-> discharge_path_en == $past(!converter_enabled && dis_q))
        else $error("discharge path wrong");
    chk_mode_select: assert property (
        $past(arst_n) |-> switch_mode == $past(voltage_set_select_pin ? m1_q : m0_q))
        else $error("switch mode wrong");
    chk_set_select: assert property (
        $past(arst_n) |-> high_set_active == $past(voltage_set_select_pin))
        else $error("set select wrong");
    chk_limit_code: assert property (
        $past(arst_n) |-> inductor_current_limit_code == $past(il_q))
        else $error("limit code wrong");
    chk_oc_set: assert property (
        $past(fault_event.overcurrent) |-> fault_flags.overcurrent)
        else $error("overcurrent flag not set");
    chk_sc_set: assert property (
        $past(fault_event.short_circuit) |-> fault_flags.short_circuit)
        else $error("short flag not set");
    chk_uv_gate: assert property (
        $rose(fault_flags.input_undervoltage)
        |-> $past(fault_event.input_undervoltage && converter_enabled))
        else $error("undervoltage flag set without cause");
    chk_flag_sticky: assert property (
        $fell(fault_flags.overcurrent)
        |-> $past(reg_req.wr && reg_req.addr == 8'h18 && !reg_req.wdata[7]))
        else $error("overcurrent flag dropped without clear");
    chk_read_limit: assert property (
        $past(reg_req.rd && reg_req.addr == 8'h16) |-> reg_rdata == {$past(il_q), 6'h00})
        else $error("limit read wrong");
    chk_read_unmapped: assert property (
        $past(reg_req.rd && !(reg_req.addr inside {8'h12, 8'h14, 8'h16, 8'h18}))
        |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : bcs_regs_asserts

bind bcs_regs bcs_regs_asserts u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .voltage_set_select_pin(voltage_set_select_pin),
    .converter_enabled(converter_enabled), .fault_event(fault_event),
    .discharge_path_en(discharge_path_en), .high_set_active(high_set_active),
    .switch_mode(switch_mode), .inductor_current_limit_code(inductor_current_limit_code),
    .fault_flags(fault_flags));

// >>> verification/bcs_host.sv
// Serial host model issuing register writes and reads to the bank
`timescale 1ns/10ps

module bcs_host
(
    input  wire logic             sys_clk,
    input  wire logic [7:0]       reg_rdata,
    output bcs_pkg::bcs_reg_req_s reg_req
);
    initial reg_req = '0;

    // Hold to the taking edge, then scramble the idle address and data
    task xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        #1 reg_req = {a, w, ~w, d};
        @(posedge sys_clk);
        #1 reg_req = {~a, 1'b0, 1'b0, ~d};
        q = reg_rdata;
    endtask : xfer

    task standby_on();
        logic [7:0] q;
        xfer(8'h12, 1'b1, 8'h00, q);
    endtask : standby_on
endmodule : bcs_host

// >>> verification/bcs_regs_tb.sv
// Self-checking bench for the converter control and status register bank
`timescale 1ns/10ps

module bcs_regs_tb;
    logic                  sys_clk;
    logic                  arst_n;
    logic                  pin;
    logic                  cen;
    bcs_pkg::bcs_fault_s   fev;
    bcs_pkg::bcs_reg_req_s req;
    logic [7:0]            rdata;
    logic                  dis_en;
    logic                  hi_act;
    bcs_pkg::bcs_sw_mode_e mode;
    bcs_pkg::bcs_ilim_t    ilim;
    bcs_pkg::bcs_fault_s   flags;
    logic [7:0]            mem [3];
    logic [7:0]            q;
    logic [7:0]            a;
    logic [7:0]            d;
    int                    fail_count;
    int                    tests_run;
    int                    seed;
    int                    i;

    bcs_regs DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
        .voltage_set_select_pin(pin), .converter_enabled(cen), .fault_event(fev),
        .discharge_path_en(dis_en), .high_set_active(hi_act), .switch_mode(mode),
        .inductor_current_limit_code(ilim), .fault_flags(flags));
    bcs_host u_host (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_req(req));

    task end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : cmp

    task cmp_flags(input logic [2:0] e);
        tests_run++;
        if (flags !== e)
        begin
            fail_count++;
            $display("wrong value fault flags exp %h got %h", e, flags);
        end
    endtask : cmp_flags

    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    // Readback of a write: only documented fields survive
    function logic [7:0] msk(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h12: return d & 8'h10;
            8'h14, 8'h16: return d & 8'hC0;
            default: return 8'h00;
        endcase
    endfunction : msk

    task rd(input logic [7:0] a, input logic [7:0] e);
        u_host.xfer(a, 1'b0, 8'h00, q);
        cmp("read data", e, q);
    endtask : rd

    task ctl();
        step(2);
        cmp("discharge", {7'h00, !cen && mem[0][4]}, {7'h00, dis_en});
        cmp("mode", {7'h00, pin ? mem[1][6] : mem[1][7]}, {7'h00, mode});
        cmp("high set", {7'h00, pin}, {7'h00, hi_act});
        cmp("limit", {6'h00, mem[2][7:6]}, {6'h00, ilim});
    endtask : ctl

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(50 * 4000);
        fail_count++;
        end_of_test();
    end

    initial
    begin
        seed = 61862;
        fail_count = 0;
        tests_run = 0;
        {pin, cen, fev, arst_n} = '0;
        mem = '{8'h10, 8'h00, 8'hC0};
        step(16);
        arst_n = 1'b1;
        rd(8'h12, 8'h10);
        rd(8'h14, 8'h00);
        rd(8'h16, 8'hC0);
        rd(8'h18, 8'h00);
        rd(8'h13, 8'h00);
        ctl();
        for (i = 0; i < 40; i++)
        begin
            a = 8'h12 + (8'($random(seed)) & 8'h07);
            d = 8'($random(seed));
            pin = 1'($random(seed));
            cen = 1'($random(seed));
            u_host.xfer(a, 1'b1, d, q);
            if (a inside {8'h12, 8'h14, 8'h16})
                mem[(a - 8'h12) >> 1] = msk(a, d);
            rd(a, msk(a, d));
            ctl();
        end
        u_host.xfer(8'h14, 1'b1, 8'h80, q);
        mem[1] = 8'h80;
        for (i = 0; i < 2; i++)
        begin
            pin = i[0];
            ctl();
        end
        cen = 1'b0;
        u_host.standby_on();
        mem[0] = 8'h00;
        ctl();
        // Each event sets its flag; ones written leave it, a zero clears it
        cen = 1'b1;
        for (i = 0; i < 3; i++)
        begin
            fev = 3'b100 >> i;
            step(1);
            fev = '0;
            d = 8'h80 >> (3 * i);
            rd(8'h18, d);
            cmp_flags(3'h4 >> i);
            u_host.xfer(8'h18, 1'b1, 8'hFF, q);
            rd(8'h18, d);
            cmp_flags(3'h4 >> i);
            u_host.xfer(8'h18, 1'b1, 8'h00, q);
            rd(8'h18, 8'h00);
            cmp_flags(3'h0);
        end
        // Event held through a zero write: the set wins
        fev = 3'h4;
        u_host.xfer(8'h18, 1'b1, 8'h00, q);
        fev = '0;
        rd(8'h18, 8'h80);
        cmp_flags(3'h4);
        u_host.xfer(8'h18, 1'b1, 8'h00, q);
        rd(8'h18, 8'h00);
        cen = 1'b0;
        fev = 3'b001;
        step(1);
        fev = '0;
        rd(8'h18, 8'h00);
        cmp_flags(3'h0);
        end_of_test();
    end
endmodule : bcs_regs_tb
